/* File: logic/phf_defines.svh */
`ifndef PHF_DEFINES_SVH
`define PHF_DEFINES_SVH
// PHY header field positions
`define PHF_POS_RATE   3
`define PHF_POS_LEN    8
`define PHF_POS_SEED   22
`define PHF_POS_BURST  26
`define PHF_POS_PRE    27
`define PHF_POS_TFC    28
`define PHF_POS_BGLSB  31
// Section lengths in bits, minus one
`define PHF_PHY_END    16'h0027
`define PHF_TAIL6_END  16'h0005
`define PHF_MAC_END    16'h004F
`define PHF_HCS_END    16'h000F
`define PHF_PAR_END    16'h002F
`define PHF_TAIL4_END  16'h0003
// MAC header octets minus the first, check octets
`define PHF_MAC_REST   13'h0009
`define PHF_FCS_OCT    13'h0004
`define PHF_FCS_BITS_M1 16'h001F
// Check word
`define PHF_CRC_INIT   16'hFFFF
`define PHF_CRC_POLY   16'h1021
// Field polynomial low byte and generator coefficients x^5..x^0
`define PHF_GF_POLY    8'h1D
`define PHF_G5         8'h7E
`define PHF_G4         8'h04
`define PHF_G3         8'h9E
`define PHF_G2         8'h3A
`define PHF_G1         8'h31
`define PHF_G0         8'h75
// Scrambler preloads, bit k-1 holds x[-k]
`define PHF_SEED_00    15'h7FFC
`define PHF_SEED_01    15'h7FFE
`define PHF_SEED_10    15'h7FFD
`define PHF_SEED_11    15'h7FFF
`endif

/* File: logic/phf_pkg.sv */
`include "phf_defines.svh"
package phf_pkg;
	// Header fields, multi-bit fields except length MSB = first letter (R1, S1, T1)
	typedef struct packed {
		logic [4:0]  rate;
		logic [11:0] length;
		logic [1:0]  seed_id_bits;
		logic        next_in_burst_flag;
		logic        next_preamble_kind;
		logic [2:0]  tx_time_freq_code;
		logic        band_group_low_bit;
	} phf_fields_s;

	typedef logic [5:0][7:0] phf_rs_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_PHY, ST_T1, ST_MAC, ST_HCS, ST_T2, ST_PAR, ST_T3,
		ST_PAY, ST_PT, ST_PAD
	} phf_state_e;

	function automatic logic [39:0] phf_build_hdr(phf_fields_s f);
		logic [39:0] h;
		h = '0;
		for (int i = 0; i < 5; i++) h[`PHF_POS_RATE + i] = f.rate[4 - i];
		h[`PHF_POS_LEN +: 12] = f.length;
		h[`PHF_POS_SEED]      = f.seed_id_bits[1];
		h[`PHF_POS_SEED + 1]  = f.seed_id_bits[0];
		h[`PHF_POS_BURST]     = f.next_in_burst_flag;
		h[`PHF_POS_PRE]       = f.next_preamble_kind;
		for (int i = 0; i < 3; i++) h[`PHF_POS_TFC + i] = f.tx_time_freq_code[2 - i];
		h[`PHF_POS_BGLSB]     = f.band_group_low_bit;
		return h;
	endfunction : phf_build_hdr

	function automatic logic [7:0] phf_gf_mul(logic [7:0] a, logic [7:0] b);
		logic [7:0] p;
		logic [7:0] s;
		p = 8'h00;
		s = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ s;
			s = s[7] ? ({s[6:0], 1'b0} ^ `PHF_GF_POLY) : {s[6:0], 1'b0};
		end
		return p;
	endfunction : phf_gf_mul

	function automatic phf_rs_t phf_rs_step(phf_rs_t r, logic [7:0] m);
		logic [7:0] fb;
		phf_rs_t    n;
		fb   = m ^ r[5];
		n[5] = r[4] ^ phf_gf_mul(fb, `PHF_G5);
		n[4] = r[3] ^ phf_gf_mul(fb, `PHF_G4);
		n[3] = r[2] ^ phf_gf_mul(fb, `PHF_G3);
		n[2] = r[1] ^ phf_gf_mul(fb, `PHF_G2);
		n[1] = r[0] ^ phf_gf_mul(fb, `PHF_G1);
		n[0] = phf_gf_mul(fb, `PHF_G0);
		return n;
	endfunction : phf_rs_step
endpackage : phf_pkg

/* File: logic/phf_framer.sv */
`timescale 1ns/1ps
`include "phf_defines.svh"
module phf_framer #(
	parameter int IBP_W = 12
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Octet stream from the MAC
	input  wire logic               in_valid,
	output logic                    in_ready,
	input  wire logic               in_sof,
	input  wire logic [7:0]         in_data,
	input  wire phf_pkg::phf_fields_s in_fields,
	// Rate configuration
	input  wire logic [IBP_W-1:0]   info_bits_per_six_symbols,
	// Bit stream to the encoder
	output logic                    out_valid,
	input  wire logic               out_ready,
	output logic                    out_bit,
	output logic                    out_hdr,
	output logic                    out_last
);

	if (IBP_W < 6 || IBP_W > 16) begin : g_chk
		$error("IBP_W out of range");
	end

	phf_pkg::phf_state_e  state_q, state_d;
	phf_pkg::phf_fields_s fld_q, fld_d;
	phf_pkg::phf_rs_t     rs_q, rs_d;
	logic [39:0]      hdr_q, hdr_d;
	logic [15:0]      cnt_q, cnt_d;
	logic [15:0]      lim_q, lim_d;
	logic [15:0]      crc_q, crc_d;
	logic [14:0]      scr_q, scr_d;
	logic [14:0]      seed;
	logic [7:0]       byte_q, byte_d;
	logic [7:0]       acc_q, acc_d;
	logic             bvld_q, bvld_d;
	logic [12:0]      left_q, left_d;
	logic [IBP_W-1:0] ibp_q, ibp_d;
	logic [IBP_W-1:0] pos_q, pos_d;
	logic             rdy_q, rdy_d;
	logic             ov_q, ov_d;
	logic             ob_q, ob_d;
	logic             oh_q, oh_d;
	logic             ol_q, ol_d;
	logic             adv, go, obit, last, sec_hdr;
	logic             xs, src, crc_en, crc_in, crc_sh;
	logic             rs_en, scr_en, scr_ld, pos_en, pos_wrap, cnt_end;

	// Preload chosen by the seed id also written into the header
	always_comb begin
		case (fld_q.seed_id_bits)
			2'h0:    seed = `PHF_SEED_00;
			2'h1:    seed = `PHF_SEED_01;
			2'h2:    seed = `PHF_SEED_10;
			default: seed = `PHF_SEED_11;
		endcase
	end

	// Next state of the whole framer
	always_comb begin
		state_d = state_q;
		fld_d   = fld_q;
		hdr_d   = hdr_q;
		cnt_d   = cnt_q;
		lim_d   = lim_q;
		crc_d   = crc_q;
		rs_d    = rs_q;
		scr_d   = scr_q;
		byte_d  = byte_q;
		acc_d   = acc_q;
		bvld_d  = bvld_q;
		left_d  = left_q;
		ibp_d   = ibp_q;
		pos_d   = pos_q;
		ov_d    = ov_q;
		ob_d    = ob_q;
		oh_d    = oh_q;
		ol_d    = ol_q;
		xs      = scr_q[13] ^ scr_q[14];
		src     = byte_q[cnt_q[2:0]];
		adv     = !ov_q || out_ready;
		go      = 1'b0;
		obit    = 1'b0;
		last    = 1'b0;
		sec_hdr = 1'b1;
		crc_en  = 1'b0;
		crc_in  = 1'b0;
		crc_sh  = 1'b0;
		rs_en   = 1'b0;
		scr_en  = 1'b0;
		scr_ld  = 1'b0;
		pos_en  = 1'b0;
		pos_wrap = (pos_q == ibp_q - 1'b1);
		cnt_end = 1'b0;
		case (state_q)
			phf_pkg::ST_IDLE: begin
				if (in_valid && rdy_q && in_sof) begin
					fld_d   = in_fields;
					hdr_d   = phf_pkg::phf_build_hdr(in_fields);
					ibp_d   = info_bits_per_six_symbols;
					byte_d  = in_data;
					bvld_d  = 1'b1;
					crc_d   = `PHF_CRC_INIT;
					rs_d    = '0;
					cnt_d   = '0;
					lim_d   = {1'b0, in_fields.length, 3'h0} + `PHF_FCS_BITS_M1;
					left_d  = (in_fields.length == 12'h000) ? `PHF_MAC_REST :
						`PHF_MAC_REST + {1'b0, in_fields.length} + `PHF_FCS_OCT;
					state_d = phf_pkg::ST_PHY;
				end
			end
			phf_pkg::ST_PHY: begin
				go      = adv;
				obit    = hdr_q[cnt_q[5:0]];
				crc_en  = adv;
				crc_in  = obit;
				rs_en   = adv;
				cnt_end = (cnt_q == `PHF_PHY_END);
			end
			phf_pkg::ST_T1, phf_pkg::ST_T2: begin
				go      = adv;
				cnt_end = (cnt_q == `PHF_TAIL6_END);
				scr_ld  = adv && cnt_end && (state_q == phf_pkg::ST_T1);
			end
			phf_pkg::ST_MAC: begin
				go      = adv && bvld_q;
				obit    = src ^ xs;
				crc_en  = go;
				crc_in  = src;
				rs_en   = go;
				scr_en  = go;
				cnt_end = (cnt_q == `PHF_MAC_END);
			end
			phf_pkg::ST_HCS: begin
				go      = adv;
				obit    = ~crc_q[15] ^ xs;
				crc_sh  = adv;
				rs_en   = adv;
				scr_en  = adv;
				cnt_end = (cnt_q == `PHF_HCS_END);
			end
			phf_pkg::ST_PAR: begin
				go      = adv;
				obit    = rs_q[5][cnt_q[2:0]];
				if (adv && cnt_q[2:0] == 3'h7) begin
					rs_d = {rs_q[4:0], 8'h00};
				end
				cnt_end = (cnt_q == `PHF_PAR_END);
			end
			phf_pkg::ST_T3: begin
				go      = adv;
				cnt_end = (cnt_q == `PHF_TAIL4_END);
				last    = cnt_end && (fld_q.length == 12'h000);
				scr_ld  = adv && cnt_end;
			end
			phf_pkg::ST_PAY: begin
				go      = adv && bvld_q;
				obit    = src ^ xs;
				sec_hdr = 1'b0;
				scr_en  = go;
				pos_en  = go;
				cnt_end = (cnt_q == lim_q);
			end
			phf_pkg::ST_PT: begin
				// Scrambler still steps so the pad keeps its place in the sequence
				go      = adv;
				sec_hdr = 1'b0;
				scr_en  = adv;
				pos_en  = adv;
				cnt_end = (cnt_q == `PHF_TAIL6_END);
				last    = cnt_end && pos_wrap;
			end
			phf_pkg::ST_PAD: begin
				go      = adv;
				obit    = xs;
				sec_hdr = 1'b0;
				scr_en  = adv;
				pos_en  = adv;
				cnt_end = pos_wrap;
				last    = pos_wrap;
			end
			default: state_d = phf_pkg::ST_IDLE;
		endcase

		// Section sequencing
		if (go) begin
			cnt_d = cnt_end ? 16'h0000 : cnt_q + 16'h0001;
			if (cnt_end) begin
				case (state_q)
					phf_pkg::ST_PHY: state_d = phf_pkg::ST_T1;
					phf_pkg::ST_T1:  state_d = phf_pkg::ST_MAC;
					phf_pkg::ST_MAC: state_d = phf_pkg::ST_HCS;
					phf_pkg::ST_HCS: state_d = phf_pkg::ST_T2;
					phf_pkg::ST_T2:  state_d = phf_pkg::ST_PAR;
					phf_pkg::ST_PAR: state_d = phf_pkg::ST_T3;
					phf_pkg::ST_T3:  state_d = last ? phf_pkg::ST_IDLE : phf_pkg::ST_PAY;
					phf_pkg::ST_PAY: state_d = phf_pkg::ST_PT;
					phf_pkg::ST_PT:  state_d = last ? phf_pkg::ST_IDLE : phf_pkg::ST_PAD;
					default:         state_d = phf_pkg::ST_IDLE;
				endcase
			end
			if (state_q inside {phf_pkg::ST_MAC, phf_pkg::ST_PAY} && cnt_q[2:0] == 3'h7) begin
				bvld_d = 1'b0;
			end
		end

		// Check word: feed header bits, then shift out the remainder
		if (crc_en) begin
			crc_d = {crc_q[14:0], 1'b0} ^ ((crc_in ^ crc_q[15]) ? `PHF_CRC_POLY : 16'h0000);
		end else if (crc_sh) begin
			crc_d = {crc_q[14:0], 1'b0};
		end

		// Outer code: gather the sent bit LSB first, update per octet
		if (rs_en) begin
			acc_d[cnt_q[2:0]] = obit;
			if (cnt_q[2:0] == 3'h7) begin
				rs_d = phf_pkg::phf_rs_step(rs_q, acc_d);
			end
		end

		// Scrambler load and step
		if (scr_ld) begin
			scr_d = seed;
		end else if (scr_en) begin
			scr_d = {scr_q[13:0], xs};
		end

		// Position inside the interleaver block
		if (state_q == phf_pkg::ST_T3) begin
			pos_d = '0;
		end else if (pos_en) begin
			pos_d = pos_wrap ? '0 : pos_q + 1'b1;
		end

		// Octet fetch outside idle
		if (in_valid && rdy_q && state_q != phf_pkg::ST_IDLE) begin
			byte_d = in_data;
			bvld_d = 1'b1;
			left_d = left_q - 13'h0001;
		end
		rdy_d = (state_d == phf_pkg::ST_IDLE) || (left_d != 13'h0000 && !bvld_d);

		// Output stage holds while the encoder stalls
		if (adv) begin
			ov_d = go;
			ob_d = obit;
			oh_d = sec_hdr;
			ol_d = last;
		end
	end

	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= phf_pkg::ST_IDLE;
			fld_q   <= '0;
			hdr_q   <= '0;
			cnt_q   <= '0;
			lim_q   <= '0;
			crc_q   <= `PHF_CRC_INIT;
			rs_q    <= '0;
			scr_q   <= '0;
			byte_q  <= '0;
			acc_q   <= '0;
			bvld_q  <= 1'b0;
			left_q  <= '0;
			ibp_q   <= '0;
			pos_q   <= '0;
			rdy_q   <= 1'b0;
			ov_q    <= 1'b0;
			ob_q    <= 1'b0;
			oh_q    <= 1'b0;
			ol_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			fld_q   <= fld_d;
			hdr_q   <= hdr_d;
			cnt_q   <= cnt_d;
			lim_q   <= lim_d;
			crc_q   <= crc_d;
			rs_q    <= rs_d;
			scr_q   <= scr_d;
			byte_q  <= byte_d;
			acc_q   <= acc_d;
			bvld_q  <= bvld_d;
			left_q  <= left_d;
			ibp_q   <= ibp_d;
			pos_q   <= pos_d;
			rdy_q   <= rdy_d;
			ov_q    <= ov_d;
			ob_q    <= ob_d;
			oh_q    <= oh_d;
			ol_q    <= ol_d;
		end
	end

	assign in_ready  = rdy_q;
	assign out_valid = ov_q;
	assign out_bit   = ob_q;
	assign out_hdr   = oh_q;
	assign out_last  = ol_q;

endmodule : phf_framer

/* File: verif/phf_framer_chk.sv */
`timescale 1ns/1ps
module phf_framer_chk #(
	parameter int IBP_W = 12
) (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  rst,
	// Octet side
	input wire logic                  in_valid,
	input wire logic                  in_ready,
	input wire logic                  in_sof,
	input wire phf_pkg::phf_fields_s  in_fields,
	input wire logic [IBP_W-1:0]      info_bits_per_six_symbols,
	// Bit side
	input wire logic                  out_valid,
	input wire logic                  out_ready,
	input wire logic                  out_bit,
	input wire logic                  out_hdr,
	input wire logic                  out_last
);
	logic [15:0]          cnt_q;
	logic [15:0]          pb;
	logic                 tl;
	logic [IBP_W-1:0]     ib_q;
	phf_pkg::phf_fields_s fs_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Bit index in the frame; fields latched with the start octet
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			fs_q  <= '0;
			ib_q  <= '0;
		end else if (in_valid && in_ready && in_sof) begin
			cnt_q <= 16'h0000;
			fs_q  <= in_fields;
			ib_q  <= info_bits_per_six_symbols;
		end else if (out_valid && out_ready) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	// Index of the first payload tail bit, and the header tail positions
	assign pb = 16'h00E8 + {1'b0, fs_q.length, 3'b000};
	assign tl = cnt_q inside {[16'h0028:16'h002D], [16'h008E:16'h0093], [16'h00C4:16'h00C7]};
	a_ready_drop: assert property (in_valid && in_ready |=> !in_ready)
		else $error("ready held after a take");
	a_stall_hold: assert property (out_valid && !out_ready |=>
		out_valid && $stable({out_bit, out_hdr, out_last})) else $error("bit moved in stall");
	// First header bit leaves one idle cycle after the start octet is taken
	a_sof_start: assert property (in_valid && in_ready && in_sof |=> ##1
		(out_valid && out_hdr && !out_bit)) else $error("frame start wrong");
	a_hdr_span: assert property (out_valid |-> out_hdr == (cnt_q < 16'h00C8))
		else $error("header flag wrong");
	a_hdr_tails: assert property (out_valid && tl |-> !out_bit)
		else $error("header tail not zero");
	a_seed_bits: assert property (out_valid && cnt_q[15:1] == 15'h000B |->
		out_bit == fs_q.seed_id_bits[~cnt_q[0]]) else $error("seed field wrong");
	a_pay_tail: assert property (out_valid && cnt_q >= pb && cnt_q < pb + 16'h0006 |-> !out_bit)
		else $error("payload tail not zero");
	a_frame_end: assert property (out_valid && out_last |-> (fs_q.length == 12'h000) ?
		cnt_q == 16'h00C7 : (cnt_q >= pb + 16'h0005 && cnt_q < pb + 16'h0005 + ib_q
		&& (cnt_q - 16'h00C7) % ib_q == 0)) else $error("frame length wrong");
	a_last_idle: assert property (out_valid && out_ready && out_last |=> !out_valid && in_ready)
		else $error("no idle after last bit");
endmodule : phf_framer_chk
bind phf_framer phf_framer_chk #(.IBP_W(IBP_W)) phf_framer_chk_i (.clk(clk), .rst(rst),
	.in_valid(in_valid), .in_ready(in_ready), .in_sof(in_sof), .in_fields(in_fields),
	.info_bits_per_six_symbols(info_bits_per_six_symbols), .out_valid(out_valid),
	.out_ready(out_ready), .out_bit(out_bit), .out_hdr(out_hdr), .out_last(out_last));

/* File: verif/phf_mac_src.sv */
`timescale 1ns/1ps
module phf_mac_src (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Bench control
	input  wire logic       go,
	input  wire logic       slow,
	input  wire logic [6:0] n,
	// Octet handshake
	input  wire logic       in_ready,
	output logic            in_valid = 1'b0,
	output logic            in_sof = 1'b0,
	output logic [7:0]      in_data = 8'h00
);
	logic [7:0] mem [0:63];
	logic       tk = 1'b0;
	int         k = 0;
	// Take seen at the rising edge, acted on at the falling edge
	always @(posedge clk) tk <= in_valid && in_ready;
	// Octet offer held until taken; slow mode leaves a gap cycle
	always @(negedge clk) begin
		if (rst || !go) begin
			k = 0;
			in_valid = 1'b0;
			in_sof = 1'b0;
		end else begin
			if (tk) begin
				k = k + 1;
			end
			// Each signal written once per edge: next offer, or a release after a take
			if (k < n && !(slow && tk)) begin
				in_valid = 1'b1;
				in_sof = (k == 0);
				in_data = mem[k];
			end else if (tk) begin
				in_valid = 1'b0;
				in_sof = 1'b0;
				in_data = ~in_data; // Released data changes, never looks valid
			end
		end
	end
endmodule : phf_mac_src

/* File: verif/phf_framer_tb.sv */
`timescale 1ns/1ps
module phf_framer_tb;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 out_ready = 1'b1;
	logic                 go = 1'b0;
	logic                 slow = 1'b0;
	logic                 stl = 1'b0;
	logic [6:0]           n_oct = 7'h00;
	logic [11:0]          ibp = 12'h001;
	logic [1:0]           sid = 2'b00;
	phf_pkg::phf_fields_s fld = '0;
	logic                 in_valid, in_ready, in_sof, out_valid, out_bit, out_hdr, out_last;
	logic [7:0]           in_data;
	logic [2:0]           exq[$];
	logic [2:0]           got[$];
	logic [7:0]           g[6] = '{8'h75, 8'h31, 8'h3A, 8'h9E, 8'h04, 8'h7E};
	int                   errors = 0;
	int                   cmp_count = 0;
	// Idle cycles the MAC keeps between frames of a burst
	localparam int        min_interframe_gap = 3;
	always #2.5 clk = ~clk;
	// Encoder side stalls every other cycle on request
	always @(negedge clk) out_ready <= stl ? ~out_ready : 1'b1;
	// Accepted bits as {bit, header, last}
	always @(posedge clk) if (out_valid === 1'b1 && out_ready) got.push_back({out_bit, out_hdr, out_last});
	phf_framer #(.IBP_W(12)) phf_framer_i (.clk(clk), .rst(rst), .in_valid(in_valid),
		.in_ready(in_ready), .in_sof(in_sof), .in_data(in_data), .in_fields(fld),
		.info_bits_per_six_symbols(ibp), .out_valid(out_valid), .out_ready(out_ready),
		.out_bit(out_bit), .out_hdr(out_hdr), .out_last(out_last));
	phf_mac_src phf_mac_src_i (.clk(clk), .rst(rst), .go(go), .slow(slow), .n(n_oct),
		.in_ready(in_ready), .in_valid(in_valid), .in_sof(in_sof), .in_data(in_data));
	function automatic logic scr(inout logic [14:0] s, input logic d);
		logic x;
		x = s[13] ^ s[14];
		s = {s[13:0], x};
		return d ^ x;
	endfunction : scr
	function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ a;
			a = a[7] ? ({a[6:0], 1'b0} ^ 8'h1D) : {a[6:0], 1'b0};
		end
		return p;
	endfunction : gm
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task give_verdict;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	// One frame: expected stream built bit by bit, then sent and compared
	task frame(input logic [4:0] rt, input logic [11:0] len, input logic bm, input logic pt,
		input logic [2:0] tc, input logic bg, input logic [11:0] ib);
		logic [39:0]  h;
		logic [15:0]  c;
		logic [14:0]  s, sd;
		logic [135:0] mb;
		logic [7:0]   r[6];
		logic [7:0]   fb;
		logic         d;
		int           i, j, t, nb;
		sd = {13'h1FFF, sid[0], sid[1]};
		h = 40'h0;
		for (i = 0; i < 5; i++) h[3 + i] = rt[4 - i];
		h[19:8] = len;
		h[23:22] = {sid[0], sid[1]};
		h[27:26] = {pt, bm};
		for (i = 0; i < 3; i++) h[28 + i] = tc[2 - i];
		h[31] = bg;
		nb = 10 + ((len > 0) ? len + 4 : 0);
		n_oct = 7'(nb);
		for (i = 0; i < nb; i++) phf_mac_src_i.mem[i] = 8'(i * 29 + 7 + sid);
		c = 16'hFFFF;
		s = sd;
		exq.delete();
		for (i = 0; i < 136; i++) begin
			d = (i < 40) ? h[i] : (i < 120) ? phf_mac_src_i.mem[(i - 40) / 8][(i - 40) % 8] : ~c[135 - i];
			if (i < 120) c = {c[14:0], 1'b0} ^ ((d ^ c[15]) ? 16'h1021 : 16'h0000);
			if (i < 40) mb[i] = d;
			else mb[i] = scr(s, d);
			exq.push_back({mb[i], 2'b10});
			if (i == 39 || i == 135) for (j = 0; j < 6; j++) exq.push_back(3'b010);
		end
		r = '{default: 8'h00};
		for (i = 0; i < 17; i++) begin
			fb = mb[8 * i +: 8] ^ r[5];
			for (j = 5; j > 0; j--) r[j] = r[j - 1] ^ gm(fb, g[j]);
			r[0] = gm(fb, g[0]);
		end
		for (i = 0; i < 52; i++) exq.push_back({(i < 48) ? r[5 - i / 8][i % 8] : 1'b0, 2'b10});
		if (len > 0) begin
			s = sd;
			for (i = 0; i < 8 * (len + 4) + 6 || i % ib != 0; i++) begin
				d = (i < 8 * (len + 4)) ? phf_mac_src_i.mem[10 + i / 8][i % 8] : 1'b0;
				d = scr(s, d);
				if (i >= 8 * (len + 4) && i < 8 * (len + 4) + 6) d = 1'b0;
				exq.push_back({d, 2'b00});
			end
		end
		exq[exq.size() - 1][0] = 1'b1;
		@(negedge clk);
		fld = '{rt, len, sid, bm, pt, tc, bg};
		ibp = ib;
		got.delete();
		go = 1'b1;
		for (t = 0; t < 5000 && got.size() < exq.size(); t++) @(negedge clk);
		go = 1'b0;
		if (t == 5000) begin
			errors++;
			give_verdict();
		end
		repeat (min_interframe_gap) @(negedge clk);
		check("bit count", 16'(got.size()), 16'(exq.size()));
		for (i = 0; i < got.size(); i++) check("bit", 16'(got[i]), 16'(exq[i]));
		sid = sid + 2'b01;
	endtask : frame
	// Empty frames through every nonzero time-frequency code, low rates
	task sc_empty;
		for (int k = 1; k < 8; k++) frame(5'(k % 5), 12'h000, 1'b1, 1'b0, {k[0], k[1], k[2]},
			k[0], 12'h00C);
	endtask : sc_empty
	// Shortest non-burst frame with a stalling encoder
	task sc_stall;
		stl = 1'b1;
		frame(5'h05, 12'h001, 1'b0, 1'b1, 3'b100, 1'b1, 12'h00C);
		stl = 1'b0;
	endtask : sc_stall
	// Slow source, long pad
	task sc_slow;
		slow = 1'b1;
		frame(5'h07, 12'h005, 1'b1, 1'b0, 3'b011, 1'b0, 12'h064);
		slow = 1'b0;
	endtask : sc_slow
	// Payload that needs no pad at all
	task sc_exact;
		frame(5'h02, 12'h001, 1'b1, 1'b0, 3'b111, 1'b1, 12'h02E);
	endtask : sc_exact
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check("ready", 16'(in_ready), 16'h0001);
		sc_empty();
		sc_stall();
		sc_slow();
		sc_exact();
		give_verdict();
	end
endmodule : phf_framer_tb
